// file: pkg/uep_pkg.sv
// package for the endpoint-0 output control and status block
// assumes a single 250 MHz system clock and an apb register bus
package uep_pkg;

  // ****************************************************************
  // register byte offsets on the apb bus
  // ****************************************************************
  localparam logic [7:0] OFS_OUT_EP0_CONFIG     = 8'h00;
  localparam logic [7:0] OFS_OUT_EP0_BYTE_COUNT = 8'h04;
  localparam logic [7:0] OFS_FUNCTION_ADDRESS   = 8'h08;
  localparam logic [7:0] OFS_USB_EVENT_STATUS   = 8'h0c;
  localparam logic [7:0] OFS_USB_EVENT_MASK     = 8'h10;
  localparam logic [7:0] OFS_EP_IRQ_STATUS      = 8'h14;
  localparam logic [7:0] OFS_EP_IRQ_MASK        = 8'h18;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CFG_XFER_IRQ_EN  = 2;
  localparam int CFG_STALL        = 3;
  localparam int CFG_TOGGLE       = 5;
  localparam int CFG_BUF_MGR_EN   = 7;
  localparam int BCNT_NAK         = 7;
  localparam int STA_SETUP_OVWR   = 0;
  localparam int STA_SETUP_RCVD   = 2;
  localparam int STA_SUSPEND      = 6;
  localparam int STA_PORT_RESET   = 7;
  localparam int EPI_XFER_DONE    = 0;
  localparam int EPI_STALL_SENT   = 1;

  // ****************************************************************
  // reset values and masks
  // ****************************************************************
  localparam logic [7:0] RST_CONFIG       = 8'h00;
  localparam logic [3:0] RST_BYTE_COUNT   = 4'h0;
  localparam logic       RST_NAK          = 1'b1;
  localparam logic [6:0] RST_FUNC_ADDR    = 7'h00;
  localparam logic [7:0] RST_STATUS       = 8'h00;
  localparam logic [7:0] RST_MASK         = 8'h00;
  localparam logic [1:0] RST_EP_IRQ       = 2'h0;
  localparam logic [7:0] STA_IMPL_MASK    = 8'hc5;
  localparam logic [3:0] COUNT_MAX        = 4'h8;
  localparam logic [31:0] APB_ERR_DATA    = 32'h0000_0000;

  // ****************************************************************
  // handshake answer to the serial interface engine
  // ****************************************************************
  typedef enum logic [3:0] {
    HSK_NONE  = 4'b0001,
    HSK_ACK   = 4'b0010,
    HSK_NAK   = 4'b0100,
    HSK_STALL = 4'b1000
  } uep_hsk_e;

  // one-cycle events from the serial interface engine, same clock
  typedef struct packed {
    logic       setupRcvd;
    logic       outToken;
    logic [3:0] outCount;
    logic [6:0] tokenAddr;
  } uep_sie_req_s;

endpackage

// file: rtl/uep_sticky.sv
// sticky flag vector: hardware sets, a clear request drops the bit
// assumes set and clear are single-cycle pulses on clk_sys
`timescale 1ns/100ps
module uep_sticky
  import uep_pkg::*;
#(
  parameter int              W      = 8,
  parameter logic [W-1:0]    RSTVAL = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic [W-1:0] setVec,
  input  wire logic [W-1:0] clrVec,
  output logic      [W-1:0] flags
);

  logic [W-1:0] flag_r;
  logic [W-1:0] flag_nxt;

  // set beats a clear landing in the same cycle, so no event is lost
  always_comb begin
    flag_nxt = (flag_r & ~clrVec) | setVec;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flag_r <= RSTVAL;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flags = flag_r;

endmodule // uep_sticky

// file: rtl/uep_ep0_out_ctrl.sv
// endpoint-0 output control, function address and usb event status
// assumes sie requests arrive on clk_sys; port reset and suspend are
// line-state levels from another domain and are synchronised here
`timescale 1ns/100ps

// Overview of operation
// RL1 - completion interrupt only when enable bit set
// RL2 - stall bit answers STALL, then self-clears
// RL3 - data toggle readable at config bit five
// RL4 - buffer manager served only when enabled
// RL5 - byte counts above eight shown as eight on ep0OutCount
// RL6 - nak flag resets set; host OUT NAKed
// RL7 - seven-bit function address, reset zero, matched
// RL8 - status flags hardware set, write-one clear
// RL9 - flag interrupts only when mask bit set
// RL10 - overwrite flag on setup over pending setup
// RL11 - setup flag set on SETUP received
// RL12 - setup pending forces NAK on IN, OUT; an OUT with the stall bit set gets STALL instead
// RL13 - port reset flagged, kept over function reset
// RL14 - suspend flag on bus suspend condition
// RL15 - mask bit zero gates overwrite interrupt
// RL16 - all enabled sources merged onto one level
module uep_ep0_out_ctrl
  import uep_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  input  uep_sie_req_s      sieReq,
  input  wire logic         inToken,
  input  wire logic         portResetPin,
  input  wire logic         suspendPin,
  output uep_hsk_e          outHandshake,
  output logic              inForceNak,
  output logic              bufMgrGrant,
  output logic [3:0]        ep0OutCount,
  output logic [6:0]        funcAddr,
  output logic              addrMatch,
  output logic              irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic        pready_r,     pready_nxt;
  logic [31:0] prdata_r,     prdata_nxt;
  logic        pslverr_r,    pslverr_nxt;
  logic        bufMgrEn_r,   bufMgrEn_nxt;
  logic        stall_r,      stall_nxt;
  logic        xferIrqEn_r,  xferIrqEn_nxt;
  logic        toggle_r,     toggle_nxt;
  logic        nak_r,        nak_nxt;
  logic [3:0]  byteCnt_r,    byteCnt_nxt;
  logic [6:0]  funcAddr_r,   funcAddr_nxt;
  logic [7:0]  mask_r,       mask_nxt;
  logic [1:0]  epMask_r,     epMask_nxt;
  uep_hsk_e    hsk_r,        hsk_nxt;
  logic        inNak_r,      inNak_nxt;
  logic        grant_r,      grant_nxt;
  logic [3:0]  cntOut_r,     cntOut_nxt;
  logic        match_r,      match_nxt;
  logic        irq_r,        irq_nxt;
  logic [1:0]  syncA_r;
  logic [1:0]  syncB_r;
  logic [1:0]  syncPrev_r;

  logic [7:0]  staSet,   staClr,   evtSta;
  logic [1:0]  epSet,    epClr,    epSta;
  logic        accDone;
  logic        wrDone;
  logic [7:0]  wByte;
  logic [1:0]  lineEdge;

  // ****************************************************************
  // line-state synchronisers
  // ****************************************************************
  // two flops before use; edge detect reads only the second stage
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      syncA_r    <= 2'h0;
      syncB_r    <= 2'h0;
      syncPrev_r <= 2'h0;
    end else begin
      syncA_r    <= {suspendPin, portResetPin};
      syncB_r    <= syncA_r;
      syncPrev_r <= syncB_r;
    end
  end

  assign lineEdge = syncB_r & ~syncPrev_r;

  // ****************************************************************
  // sticky flags
  // ****************************************************************
  uep_sticky #(.W(8), .RSTVAL(RST_STATUS)) u_evt_sta (
    .clk_sys (clk_sys),
    .reset   (reset),
    .setVec  (staSet),
    .clrVec  (staClr),
    .flags   (evtSta)
  );

  uep_sticky #(.W(2), .RSTVAL(RST_EP_IRQ)) u_ep_sta (
    .clk_sys (clk_sys),
    .reset   (reset),
    .setVec  (epSet),
    .clrVec  (epClr),
    .flags   (epSta)
  );

  // ****************************************************************
  // apb slave
  // ****************************************************************
  // one wait state: data and ready are both registered
  assign accDone = psel & penable & pready_r;
  assign wrDone  = accDone & pwrite;
  assign wByte   = pwdata[7:0];

  always_comb begin
    pready_nxt  = psel & penable & ~pready_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    if (psel & penable & ~pready_r) begin
      prdata_nxt = APB_ERR_DATA;
      unique case (paddr)
        OFS_OUT_EP0_CONFIG: begin
          prdata_nxt[CFG_BUF_MGR_EN]  = bufMgrEn_r;
          prdata_nxt[CFG_TOGGLE]      = toggle_r;     // [RL3]
          prdata_nxt[CFG_STALL]       = stall_r;
          prdata_nxt[CFG_XFER_IRQ_EN] = xferIrqEn_r;
        end
        OFS_OUT_EP0_BYTE_COUNT: begin
          prdata_nxt[BCNT_NAK] = nak_r;
          prdata_nxt[3:0]      = byteCnt_r;
        end
        OFS_FUNCTION_ADDRESS: prdata_nxt[6:0] = funcAddr_r;
        OFS_USB_EVENT_STATUS: prdata_nxt[7:0] = evtSta;
        OFS_USB_EVENT_MASK:   prdata_nxt[7:0] = mask_r;
        OFS_EP_IRQ_STATUS:    prdata_nxt[1:0] = epSta;
        OFS_EP_IRQ_MASK:      prdata_nxt[1:0] = epMask_r;
        default:              pslverr_nxt     = 1'b1;
      endcase
    end
  end

  // ****************************************************************
  // endpoint, address and event logic
  // ****************************************************************
  // software writes first, hardware effects last where hardware wins
  always_comb begin
    bufMgrEn_nxt  = bufMgrEn_r;
    stall_nxt     = stall_r;
    xferIrqEn_nxt = xferIrqEn_r;
    toggle_nxt    = toggle_r;
    nak_nxt       = nak_r;
    byteCnt_nxt   = byteCnt_r;
    funcAddr_nxt  = funcAddr_r;
    mask_nxt      = mask_r;
    epMask_nxt    = epMask_r;
    hsk_nxt       = HSK_NONE;
    grant_nxt     = 1'b0;
    staSet        = 8'h00;
    staClr        = 8'h00;
    epSet         = 2'h0;
    epClr         = 2'h0;

    // software register writes
    if (wrDone) begin
      unique case (paddr)
        OFS_OUT_EP0_CONFIG: begin
          bufMgrEn_nxt  = wByte[CFG_BUF_MGR_EN];
          stall_nxt     = wByte[CFG_STALL];
          xferIrqEn_nxt = wByte[CFG_XFER_IRQ_EN];
        end
        OFS_OUT_EP0_BYTE_COUNT: begin
          nak_nxt     = wByte[BCNT_NAK];             // [RL6]
          byteCnt_nxt = wByte[3:0];
        end
        OFS_FUNCTION_ADDRESS: funcAddr_nxt = wByte[6:0];   // [RL7]
        OFS_USB_EVENT_STATUS: staClr = wByte & STA_IMPL_MASK;  // [RL8]
        OFS_USB_EVENT_MASK:   mask_nxt = wByte & STA_IMPL_MASK;  // [RL15]
        OFS_EP_IRQ_MASK:      epMask_nxt = wByte[1:0];
        default: ;
      endcase
    end
    // reading the endpoint event register clears only what was shown
    if (accDone & ~pwrite & (paddr == OFS_EP_IRQ_STATUS)) begin
      epClr = prdata_r[1:0];
    end

    // function reset from the line: address and toggle restart
    if (lineEdge[0]) begin
      funcAddr_nxt = RST_FUNC_ADDR;
      toggle_nxt   = 1'b0;
    end
    staSet[STA_PORT_RESET] = lineEdge[0];  // [RL13]
    staSet[STA_SUSPEND]    = lineEdge[1];  // [RL14]

    // setup packet: flag it, note overwrite, data stage starts DATA1
    if (sieReq.setupRcvd) begin
      staSet[STA_SETUP_RCVD] = 1'b1;                    // [RL11]
      staSet[STA_SETUP_OVWR] = evtSta[STA_SETUP_RCVD];  // [RL10]
      toggle_nxt             = 1'b1;
    end

    // host OUT: stall first, then pending setup or full buffer
    if (sieReq.outToken) begin
      if (stall_r) begin
        hsk_nxt              = HSK_STALL;  // [RL2]
        stall_nxt            = 1'b0;       // [RL2]
        epSet[EPI_STALL_SENT] = 1'b1;
      end else if (evtSta[STA_SETUP_RCVD] | nak_r) begin
        hsk_nxt = HSK_NAK;                 // [RL6] [RL12]
      end else begin
        hsk_nxt              = HSK_ACK;
        byteCnt_nxt          = sieReq.outCount;
        nak_nxt              = 1'b1;       // [RL6]
        toggle_nxt           = ~toggle_r;  // [RL3]
        grant_nxt            = bufMgrEn_r; // [RL4]
        epSet[EPI_XFER_DONE] = xferIrqEn_r;  // [RL1]
      end
    end
  end

  // outward views, all registered
  always_comb begin
    inNak_nxt  = evtSta[STA_SETUP_RCVD] & inToken;  // [RL12]
    cntOut_nxt = (byteCnt_r > COUNT_MAX) ? COUNT_MAX : byteCnt_r;  // [RL5]
    match_nxt  = sieReq.tokenAddr == funcAddr_r;    // [RL7]
    irq_nxt    = (|(evtSta & mask_r)) | (|(epSta & epMask_r));  // [RL9] [RL16]
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready_r    <= 1'b0;
      prdata_r    <= APB_ERR_DATA;
      pslverr_r   <= 1'b0;
      bufMgrEn_r  <= RST_CONFIG[CFG_BUF_MGR_EN];
      stall_r     <= RST_CONFIG[CFG_STALL];
      xferIrqEn_r <= RST_CONFIG[CFG_XFER_IRQ_EN];
      toggle_r    <= RST_CONFIG[CFG_TOGGLE];
      nak_r       <= RST_NAK;        // [RL6]
      byteCnt_r   <= RST_BYTE_COUNT;
      funcAddr_r  <= RST_FUNC_ADDR;  // [RL7]
      mask_r      <= RST_MASK;
      epMask_r    <= RST_EP_IRQ;
      hsk_r       <= HSK_NONE;
      inNak_r     <= 1'b0;
      grant_r     <= 1'b0;
      cntOut_r    <= RST_BYTE_COUNT;
      match_r     <= 1'b0;
      irq_r       <= 1'b0;
    end else begin
      pready_r    <= pready_nxt;
      prdata_r    <= prdata_nxt;
      pslverr_r   <= pslverr_nxt;
      bufMgrEn_r  <= bufMgrEn_nxt;
      stall_r     <= stall_nxt;
      xferIrqEn_r <= xferIrqEn_nxt;
      toggle_r    <= toggle_nxt;
      nak_r       <= nak_nxt;
      byteCnt_r   <= byteCnt_nxt;
      funcAddr_r  <= funcAddr_nxt;
      mask_r      <= mask_nxt;
      epMask_r    <= epMask_nxt;
      hsk_r       <= hsk_nxt;
      inNak_r     <= inNak_nxt;
      grant_r     <= grant_nxt;
      cntOut_r    <= cntOut_nxt;
      match_r     <= match_nxt;
      irq_r       <= irq_nxt;
    end
  end

  assign pready       = pready_r;
  assign prdata       = prdata_r;
  assign pslverr      = pslverr_r;
  assign outHandshake = hsk_r;
  assign inForceNak   = inNak_r;
  assign bufMgrGrant  = grant_r;
  assign ep0OutCount  = cntOut_r;
  assign funcAddr     = funcAddr_r;
  assign addrMatch    = match_r;
  assign irq          = irq_r;

endmodule // uep_ep0_out_ctrl

// file: bench/uep_ep0_properties.sv
// checker for the ep0 out block, watching its ports only
// assumes one clock domain and a synchronous reset
`timescale 1ns/100ps
module uep_ep0_properties
  import uep_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input uep_sie_req_s    sieReq,
  input wire logic       inToken,
  input uep_hsk_e        outHandshake,
  input wire logic       inForceNak,
  input wire logic       bufMgrGrant,
  input wire logic [3:0] ep0OutCount,
  input wire logic [6:0] funcAddr,
  input wire logic       addrMatch
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_apb_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_out_answer: assert property (sieReq.outToken |=> outHandshake != HSK_NONE)
    else $error("out token unanswered");
  a_hsk_cause: assert property (outHandshake != HSK_NONE |-> $past(sieReq.outToken))
    else $error("handshake without token");
  a_grant_ack: assert property (bufMgrGrant |-> outHandshake == HSK_ACK)
    else $error("grant without ack");
  a_count_clamp: assert property (ep0OutCount <= COUNT_MAX)
    else $error("count above eight");
  a_in_nak: assert property (inForceNak |-> $past(inToken))
    else $error("in nak without token");
  a_addr_match: assert property (!$past(reset) |->
    addrMatch == ($past(sieReq.tokenAddr) == $past(funcAddr)))
    else $error("address match wrong");
endmodule // uep_ep0_properties

bind uep_ep0_out_ctrl uep_ep0_properties chk_u (.clk_sys, .reset, .psel, .penable, .pready,
  .pslverr, .sieReq, .inToken, .outHandshake, .inForceNak, .bufMgrGrant, .ep0OutCount,
  .funcAddr, .addrMatch);

// file: bench/uep_host_model.sv
// host side model: tokens via the serial engine and line states
// assumes tasks are called from the bench on clk_sys
`timescale 1ns/100ps
module uep_host_model
  import uep_pkg::*;
(
  input wire logic clk_sys,
  output uep_sie_req_s sieReq,
  output logic     inToken,
  output logic     portResetPin,
  output logic     suspendPin
);
  // ****
  // token drivers
  // ****
  initial sieReq = '0;
  initial inToken = 1'b0;
  initial portResetPin = 1'b0;
  initial suspendPin = 1'b0;
  // released fields show the inverse, never a stale copy
  task automatic sendOut(input logic [3:0] c, input logic [6:0] a);
    @(posedge clk_sys);
    sieReq <= '{1'b0, 1'b1, c, a};
    @(posedge clk_sys);
    sieReq <= '{1'b0, 1'b0, ~c, ~a};
  endtask
  task automatic sendSetup;
    @(posedge clk_sys);
    sieReq.setupRcvd <= 1'b1;
    @(posedge clk_sys);
    sieReq.setupRcvd <= 1'b0;
  endtask
  task automatic sendIn;
    @(posedge clk_sys);
    inToken <= 1'b1;
    @(posedge clk_sys);
    inToken <= 1'b0;
  endtask
  task automatic line(input logic r, input logic s);
    @(posedge clk_sys);
    portResetPin <= r;
    suspendPin <= s;
  endtask
endmodule // uep_host_model

// file: bench/tb.sv
// self-checking bench for the ep0 out block
// assumes the host model and the bound checker
`timescale 1ns/100ps
module tb;
  import uep_pkg::*;
  logic clk_sys = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, inToken, portResetPin, suspendPin;
  logic inForceNak, bufMgrGrant, addrMatch, irq;
  logic [3:0] ep0OutCount;
  logic [6:0] funcAddr;
  uep_sie_req_s sieReq;
  uep_hsk_e outHandshake;
  int failures = 0, total_checks = 0, cyc = 0;
  // ****
  // harness
  // ****
  always #2 clk_sys = ~clk_sys;
  uep_ep0_out_ctrl dut_u (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .sieReq, .inToken, .portResetPin, .suspendPin,
    .outHandshake, .inForceNak, .bufMgrGrant, .ep0OutCount, .funcAddr, .addrMatch, .irq);
  uep_host_model host_u (.clk_sys, .sieReq, .inToken, .portResetPin, .suspendPin);
  // hang guard, far above the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one apb transfer; waits a fresh edge so psel never toggles twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    apb(0, OFS_OUT_EP0_CONFIG, 0);
    chk(rd, 32'h0);
    apb(0, OFS_OUT_EP0_BYTE_COUNT, 0);
    chk(rd, 32'h80);
    apb(0, OFS_FUNCTION_ADDRESS, 0);
    chk(rd, 32'h0);
    apb(0, OFS_USB_EVENT_STATUS, 0);
    chk(rd, 32'h0);
    apb(0, OFS_USB_EVENT_MASK, 0);
    chk(rd, 32'h0);
    apb(0, OFS_EP_IRQ_MASK, 0);
    chk(rd, 32'h0);
    chk(irq, 1'b0);
    apb(0, 8'h1c, 0);
    chk(er, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_out;
    logic [3:0] c;
    apb(1, OFS_EP_IRQ_MASK, 32'h1);
    for (int en = 0; en < 2; en++) begin
      c = en ? 4'hb : 4'h3;
      apb(1, OFS_OUT_EP0_BYTE_COUNT, 32'h0);
      apb(1, OFS_OUT_EP0_CONFIG, {24'h0, en[0], 4'h0, en[0], 2'h0});
      host_u.sendOut(c, 7'h00);
      @(negedge clk_sys);
      chk(outHandshake, HSK_ACK);
      chk(bufMgrGrant, en[0]);
      idle(3);
      chk(ep0OutCount, en ? 4'h8 : 4'h3);
      chk(irq, en[0]);
      apb(0, OFS_OUT_EP0_BYTE_COUNT, 0);
      chk(rd, {24'h0, 4'h8, c});
      apb(0, OFS_OUT_EP0_CONFIG, 0);
      chk(rd, {24'h0, en[0], 1'b0, ~en[0], 2'h0, en[0], 2'h0});
      apb(0, OFS_EP_IRQ_STATUS, 0);
      chk(rd, {31'h0, en[0]});
    end
    host_u.sendOut(4'h1, 7'h00);
    @(negedge clk_sys);
    chk(outHandshake, HSK_NAK);
    idle(2);
    chk(irq, 1'b0);
    $display("out test done");
  endtask
  task automatic t_stall;
    apb(1, OFS_OUT_EP0_CONFIG, 32'h08);
    host_u.sendOut(4'h1, 7'h00);
    @(negedge clk_sys);
    chk(outHandshake, HSK_STALL);
    apb(0, OFS_OUT_EP0_CONFIG, 0);
    chk(rd[3], 1'b0);
    apb(0, OFS_EP_IRQ_STATUS, 0);
    chk(rd, 32'h2);
    apb(0, OFS_EP_IRQ_STATUS, 0);
    chk(rd, 32'h0);
    host_u.sendOut(4'h1, 7'h00);
    @(negedge clk_sys);
    chk(outHandshake, HSK_NAK);
    $display("stall test done");
  endtask
  task automatic t_setup;
    apb(1, OFS_USB_EVENT_MASK, 32'h01);
    apb(1, OFS_OUT_EP0_BYTE_COUNT, 32'h0);
    host_u.sendSetup();
    idle(2);
    apb(0, OFS_USB_EVENT_STATUS, 0);
    chk(rd, 32'h04);
    chk(irq, 1'b0);
    host_u.sendIn();
    @(negedge clk_sys);
    chk(inForceNak, 1'b1);
    host_u.sendOut(4'h2, 7'h00);
    @(negedge clk_sys);
    chk(outHandshake, HSK_NAK);
    host_u.sendSetup();
    idle(3);
    chk(irq, 1'b1);
    apb(1, OFS_USB_EVENT_MASK, 32'h00);
    idle(2);
    chk(irq, 1'b0);
    apb(1, OFS_USB_EVENT_MASK, 32'h01);
    idle(2);
    chk(irq, 1'b1);
    apb(1, OFS_USB_EVENT_STATUS, 32'h0);
    apb(0, OFS_USB_EVENT_STATUS, 0);
    chk(rd, 32'h05);
    apb(1, OFS_USB_EVENT_STATUS, 32'h05);
    apb(0, OFS_USB_EVENT_STATUS, 0);
    chk(rd, 32'h0);
    chk(irq, 1'b0);
    $display("setup test done");
  endtask
  task automatic t_addr;
    apb(1, OFS_FUNCTION_ADDRESS, 32'haa);
    apb(0, OFS_FUNCTION_ADDRESS, 0);
    chk(rd, 32'h2a);
    host_u.sendOut(4'h0, 7'h2a);
    @(negedge clk_sys);
    chk(addrMatch, 1'b1);
    host_u.sendOut(4'h0, 7'h15);
    @(negedge clk_sys);
    chk(addrMatch, 1'b0);
    $display("address test done");
  endtask
  task automatic t_line;
    apb(1, OFS_USB_EVENT_MASK, 32'hc0);
    apb(0, OFS_USB_EVENT_MASK, 0);
    chk(rd, 32'hc0);
    host_u.line(1'b1, 1'b0);
    idle(5);
    apb(0, OFS_USB_EVENT_STATUS, 0);
    chk(rd, 32'h80);
    chk(funcAddr, 7'h00);
    chk(irq, 1'b1);
    host_u.line(1'b0, 1'b1);
    idle(5);
    apb(0, OFS_USB_EVENT_STATUS, 0);
    chk(rd, 32'hc0);
    host_u.line(1'b0, 1'b0);
    apb(1, OFS_USB_EVENT_STATUS, 32'hc0);
    idle(2);
    chk(irq, 1'b0);
    $display("line test done");
  endtask
  initial begin
    idle(12);
    reset <= 1'b0;
    t_reset();
    t_out();
    t_stall();
    t_setup();
    t_addr();
    t_line();
    finish_test();
  end
endmodule // tb
